// [ramp_seq_pkg.sv]
// Purpose: shared constants and carriers for the two-segment ramp sequencer
// Assumes: registers are 16 bits wide, one per aligned 32-bit bus word
// Notes: offsets are register indices; byte address is four times the index
package ramp_seq_pkg;
  localparam logic [6:0] IDX_GLOBAL_CTRL = 7'h00;
  localparam logic [6:0] IDX_TRIGGER_SEL = 7'h61;
  localparam logic [6:0] IDX_FIRST_STEP_HIGH = 7'h62;
  localparam logic [6:0] IDX_FIRST_STEP_LOW = 7'h63;
  localparam logic [6:0] IDX_FIRST_LENGTH = 7'h64;
  localparam logic [6:0] IDX_SEGMENT_SEQUENCE_CONTROL = 7'h65;
  localparam logic [6:0] IDX_SECOND_STEP_HIGH = 7'h66;
  localparam logic [6:0] IDX_SECOND_STEP_LOW = 7'h67;
  localparam logic [6:0] IDX_SECOND_LENGTH = 7'h68;
  localparam logic [6:0] IDX_CALIBRATION_WAIT_AND_MODE = 7'h69;
  localparam logic [6:0] IDX_CALIBRATION_SCALE_CONTROL = 7'h6A;
  localparam logic [6:0] IDX_LOCK_AND_CORE_READBACK = 7'h6E;
  localparam logic [6:0] IDX_BAND_CODE_READBACK = 7'h6F;
  localparam logic [6:0] IDX_AMPLITUDE_READBACK = 7'h70;
  localparam logic [6:0] IDX_SEQUENCER_STATUS = 7'h71;

  localparam int BIT_RAMP_ENABLE = 15;
  localparam int BIT_FIRST_DOUBLE = 0;
  localparam int BIT_SECOND_DOUBLE = 6;
  localparam int BIT_RESIDUE_CLEAR = 5;
  localparam int BIT_FIRST_SUCCESSOR = 4;
  localparam int BIT_SECOND_SUCCESSOR = 4;
  localparam int BIT_MANUAL_MODE = 5;
  localparam int BIT_CAL_AFTER_SWEEP = 4;

  localparam logic [15:0] RST_REG = 16'h0000;
  localparam logic [15:0] RST_SCALE_CTRL = 16'h0007;
  localparam logic [7:0] RST_BAND = 8'hB7;
  localparam logic [8:0] RST_AMPLITUDE = 9'h0AA;

  localparam logic [1:0] ADV_LENGTH = 2'h0;
  localparam logic [1:0] ADV_TRIG_A = 2'h1;
  localparam logic [1:0] ADV_TRIG_B = 2'h2;

  localparam logic [3:0] TRG_OFF = 4'h0;
  localparam logic [3:0] TRG_CLK_RISE = 4'h1;
  localparam logic [3:0] TRG_DIR_RISE = 4'h2;
  localparam logic [3:0] TRG_ALWAYS = 4'h4;
  localparam logic [3:0] TRG_CLK_FALL = 4'h9;
  localparam logic [3:0] TRG_DIR_FALL = 4'hA;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_FIRST = 2'b01,
    ST_SECOND = 2'b10,
    ST_CAL_WAIT = 2'b11
  } seq_state_type;

  typedef struct packed {
    logic [1:0] lock_status;
    logic [2:0] core;
    logic [7:0] band;
    logic [8:0] amplitude;
  } cal_result_type;

  typedef struct packed {
    logic [29:0] step;
    logic [15:0] length;
    logic doubled;
    logic successor;
    logic [1:0] advance_source;
  } segment_cfg_type;
endpackage

// [ramp_sequencer.sv]
// Purpose: two-segment frequency ramp sequencer with calibration readback
// Assumes: i_core_clk is the phase detector clock; pins are synchronous
// Notes: Avalon-MM slave, 32-bit data, register data in bits 15:0
`timescale 1ns/1ns
`default_nettype none
module ramp_sequencer (
  input wire logic i_core_clk,
  input wire logic i_srst,
  input wire logic i_clk_en,
  input wire logic [8:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  input wire logic i_sweep_clock_pin,
  input wire logic i_sweep_direction_pin,
  input wire logic i_cal_done,
  input wire ramp_seq_pkg::cal_result_type i_cal_result,
  output logic o_cal_start,
  output logic [31:0] o_ramp_accum,
  output logic o_ramp_active
);
  logic [15:0] glob_r, trig_r, f_hi_r, f_lo_r, f_len_r, seq_r;
  logic [15:0] s_hi_r, s_lo_r, s_len_r, wait_r, scale_r;
  ramp_seq_pkg::cal_result_type cal_r;
  ramp_seq_pkg::seq_state_type state_r, state_nxt;
  logic [31:0] accum_r, readdata_r;
  logic [16:0] len_cnt_r;
  logic half_r, resp_r, cal_start_r, cal_seen_r;
  logic [16:0] wait_cnt_r;
  logic clk_d_r, dir_d_r;

  // one-cycle answer: waitrequest drops in the cycle after the request rises
  wire req = i_avs_read | i_avs_write;
  // a frozen clock enable keeps the request waiting, so no access is reported done unseen
  assign o_avs_waitrequest = req & ~(resp_r & i_clk_en);
  wire acc_done = req & resp_r & i_clk_en;
  wire wr_en = i_avs_write & acc_done & (&i_avs_byteenable[1:0]);
  wire [6:0] idx = i_avs_address[8:2];

  function automatic logic trig_hit(input logic [3:0] sel, input logic ck, input logic ckd,
                                    input logic dr, input logic drd);
    unique case (sel)
      ramp_seq_pkg::TRG_CLK_RISE: trig_hit = ck & ~ckd;
      ramp_seq_pkg::TRG_DIR_RISE: trig_hit = dr & ~drd;
      ramp_seq_pkg::TRG_ALWAYS: trig_hit = 1'b1;
      ramp_seq_pkg::TRG_CLK_FALL: trig_hit = ~ck & ckd;
      ramp_seq_pkg::TRG_DIR_FALL: trig_hit = ~dr & drd;
      default: trig_hit = 1'b0;
    endcase
  endfunction

  function automatic logic adv_hit(input logic [1:0] src, input logic expired,
                                   input logic ta, input logic tb);
    unique case (src)
      ramp_seq_pkg::ADV_LENGTH: adv_hit = expired;
      ramp_seq_pkg::ADV_TRIG_A: adv_hit = ta;
      ramp_seq_pkg::ADV_TRIG_B: adv_hit = tb;
      default: adv_hit = 1'b0;
    endcase
  endfunction

  wire trig_a = trig_hit(trig_r[6:3], i_sweep_clock_pin, clk_d_r,
                         i_sweep_direction_pin, dir_d_r);
  wire trig_b = trig_hit(trig_r[10:7], i_sweep_clock_pin, clk_d_r,
                         i_sweep_direction_pin, dir_d_r);

  ramp_seq_pkg::segment_cfg_type first_cfg, second_cfg, cur_cfg;
  assign first_cfg = '{step: {f_hi_r[15:2], f_lo_r}, length: f_len_r,
                       doubled: f_hi_r[ramp_seq_pkg::BIT_FIRST_DOUBLE],
                       successor: seq_r[ramp_seq_pkg::BIT_FIRST_SUCCESSOR],
                       advance_source: seq_r[1:0]};
  assign second_cfg = '{step: {s_hi_r[13:0], s_lo_r}, length: s_len_r,
                        doubled: seq_r[ramp_seq_pkg::BIT_SECOND_DOUBLE],
                        successor: wait_r[ramp_seq_pkg::BIT_SECOND_SUCCESSOR],
                        advance_source: wait_r[1:0]};
  assign cur_cfg = (state_r == ramp_seq_pkg::ST_SECOND) ? second_cfg : first_cfg;

  wire ramp_en = glob_r[ramp_seq_pkg::BIT_RAMP_ENABLE];
  wire manual = wait_r[ramp_seq_pkg::BIT_MANUAL_MODE];
  wire cal_after = scale_r[ramp_seq_pkg::BIT_CAL_AFTER_SWEEP];
  wire running = (state_r == ramp_seq_pkg::ST_FIRST) | (state_r == ramp_seq_pkg::ST_SECOND);
  wire tick = running & (~cur_cfg.doubled | half_r);
  // length is counted in cycles and shifted left when doubled, so doubling also doubles the duration
  wire [16:0] len_full = {1'b0, cur_cfg.length} << cur_cfg.doubled;
  wire expired = running & (len_cnt_r + 17'h00001 >= len_full);
  wire adv = running & adv_hit(cur_cfg.advance_source, expired, trig_a, trig_b);
  wire [31:0] step_ext = {{2{cur_cfg.step[29]}}, cur_cfg.step};
  // wait = count * 2^scale; 10 + 7 bits fit in 17
  wire [16:0] wait_target = {7'h00, wait_r[15:6]} << scale_r[2:0];
  wire wait_over = (wait_cnt_r >= wait_target) & (cal_seen_r | i_cal_done);
  wire seg_succ = cur_cfg.successor;
  wire next_is_second = seg_succ;
  // sweep completes when the sequence returns to the first segment
  wire sweep_end = adv & ~next_is_second & (state_r == ramp_seq_pkg::ST_SECOND
                   | ~first_cfg.successor);
  wire do_cal = sweep_end & cal_after & ~manual;

  always_comb begin
    state_nxt = state_r;
    if (!ramp_en) begin
      state_nxt = ramp_seq_pkg::ST_IDLE;
    end else begin
      unique case (state_r)
        ramp_seq_pkg::ST_IDLE: state_nxt = ramp_seq_pkg::ST_FIRST;
        ramp_seq_pkg::ST_FIRST,
        ramp_seq_pkg::ST_SECOND: begin
          if (do_cal) begin
            state_nxt = ramp_seq_pkg::ST_CAL_WAIT;
          end else if (adv) begin
            state_nxt = next_is_second ? ramp_seq_pkg::ST_SECOND : ramp_seq_pkg::ST_FIRST;
          end
        end
        ramp_seq_pkg::ST_CAL_WAIT: begin
          if (wait_over) begin
            state_nxt = ramp_seq_pkg::ST_FIRST;
          end
        end
      endcase
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      state_r <= ramp_seq_pkg::ST_IDLE;
      accum_r <= 32'h00000000;
      len_cnt_r <= 17'h00000;
      half_r <= 1'b0;
      wait_cnt_r <= 17'h00000;
      cal_start_r <= 1'b0;
      cal_seen_r <= 1'b0;
      clk_d_r <= 1'b0;
      dir_d_r <= 1'b0;
    end else if (i_clk_en) begin
      state_r <= state_nxt;
      clk_d_r <= i_sweep_clock_pin;
      dir_d_r <= i_sweep_direction_pin;
      cal_start_r <= (state_nxt == ramp_seq_pkg::ST_CAL_WAIT) &
                     (state_r != ramp_seq_pkg::ST_CAL_WAIT);
      half_r <= running & (state_nxt == state_r) & ~adv & ~half_r;
      if (state_nxt != state_r || adv) begin
        len_cnt_r <= 17'h00000;
      end else if (running) begin
        len_cnt_r <= len_cnt_r + 17'h00001;
      end
      if (tick) begin
        accum_r <= accum_r + step_ext;
      end
      // residue clear: realign the accumulator at the start of the second segment
      if (adv && next_is_second && seq_r[ramp_seq_pkg::BIT_RESIDUE_CLEAR] && !manual) begin
        accum_r <= 32'h00000000;
      end
      if (state_r == ramp_seq_pkg::ST_CAL_WAIT) begin
        wait_cnt_r <= wait_cnt_r + 17'h00001;
        cal_seen_r <= cal_seen_r | i_cal_done;
      end else begin
        wait_cnt_r <= 17'h00000;
        cal_seen_r <= 1'b0;
      end
    end
  end

  // register writes
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      glob_r <= ramp_seq_pkg::RST_REG;
      trig_r <= ramp_seq_pkg::RST_REG;
      f_hi_r <= ramp_seq_pkg::RST_REG;
      f_lo_r <= ramp_seq_pkg::RST_REG;
      f_len_r <= ramp_seq_pkg::RST_REG;
      seq_r <= ramp_seq_pkg::RST_REG;
      s_hi_r <= ramp_seq_pkg::RST_REG;
      s_lo_r <= ramp_seq_pkg::RST_REG;
      s_len_r <= ramp_seq_pkg::RST_REG;
      wait_r <= ramp_seq_pkg::RST_REG;
      scale_r <= ramp_seq_pkg::RST_SCALE_CTRL;
    end else if (wr_en) begin
      unique case (idx)
        ramp_seq_pkg::IDX_GLOBAL_CTRL: glob_r <= i_avs_writedata[15:0];
        ramp_seq_pkg::IDX_TRIGGER_SEL: trig_r <= i_avs_writedata[15:0];
        ramp_seq_pkg::IDX_FIRST_STEP_HIGH: f_hi_r <= i_avs_writedata[15:0];
        ramp_seq_pkg::IDX_FIRST_STEP_LOW: f_lo_r <= i_avs_writedata[15:0];
        ramp_seq_pkg::IDX_FIRST_LENGTH: f_len_r <= i_avs_writedata[15:0];
        ramp_seq_pkg::IDX_SEGMENT_SEQUENCE_CONTROL: seq_r <= i_avs_writedata[15:0];
        ramp_seq_pkg::IDX_SECOND_STEP_HIGH: s_hi_r <= i_avs_writedata[15:0];
        ramp_seq_pkg::IDX_SECOND_STEP_LOW: s_lo_r <= i_avs_writedata[15:0];
        ramp_seq_pkg::IDX_SECOND_LENGTH: s_len_r <= i_avs_writedata[15:0];
        ramp_seq_pkg::IDX_CALIBRATION_WAIT_AND_MODE: wait_r <= i_avs_writedata[15:0];
        ramp_seq_pkg::IDX_CALIBRATION_SCALE_CONTROL: scale_r <= i_avs_writedata[15:0];
        default: ;
      endcase
    end
  end

  // calibration results captured when the engine reports done
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      cal_r <= '{lock_status: 2'h0, core: 3'h0, band: ramp_seq_pkg::RST_BAND,
                 amplitude: ramp_seq_pkg::RST_AMPLITUDE};
    end else if (i_clk_en && i_cal_done) begin
      cal_r <= i_cal_result;
    end
  end

  wire [15:0] f_hi_rd = {f_hi_r[15:2], 1'b0, f_hi_r[0]};
  wire [15:0] seq_rd = {9'h000, seq_r[6:4], 2'h0, seq_r[1:0]};
  wire [15:0] s_hi_rd = {2'h0, s_hi_r[13:0]};
  wire [15:0] wait_rd = {wait_r[15:4], 2'h0, wait_r[1:0]};
  wire [15:0] scale_rd = {11'h000, scale_r[4], 1'b0, scale_r[2:0]};
  wire [15:0] lock_rd = {5'h00, cal_r.lock_status, 1'b0, cal_r.core, 5'h00};
  logic [15:0] rd_mux;
  always_comb begin
    unique case (idx)
      ramp_seq_pkg::IDX_GLOBAL_CTRL: rd_mux = glob_r;
      ramp_seq_pkg::IDX_TRIGGER_SEL: rd_mux = trig_r;
      ramp_seq_pkg::IDX_FIRST_STEP_HIGH: rd_mux = f_hi_rd;
      ramp_seq_pkg::IDX_FIRST_STEP_LOW: rd_mux = f_lo_r;
      ramp_seq_pkg::IDX_FIRST_LENGTH: rd_mux = f_len_r;
      ramp_seq_pkg::IDX_SEGMENT_SEQUENCE_CONTROL: rd_mux = seq_rd;
      ramp_seq_pkg::IDX_SECOND_STEP_HIGH: rd_mux = s_hi_rd;
      ramp_seq_pkg::IDX_SECOND_STEP_LOW: rd_mux = s_lo_r;
      ramp_seq_pkg::IDX_SECOND_LENGTH: rd_mux = s_len_r;
      ramp_seq_pkg::IDX_CALIBRATION_WAIT_AND_MODE: rd_mux = wait_rd;
      ramp_seq_pkg::IDX_CALIBRATION_SCALE_CONTROL: rd_mux = scale_rd;
      ramp_seq_pkg::IDX_LOCK_AND_CORE_READBACK: rd_mux = lock_rd;
      ramp_seq_pkg::IDX_BAND_CODE_READBACK: rd_mux = {8'h00, cal_r.band};
      ramp_seq_pkg::IDX_AMPLITUDE_READBACK: rd_mux = {7'h00, cal_r.amplitude};
      ramp_seq_pkg::IDX_SEQUENCER_STATUS: rd_mux = {14'h0000, state_r};
      default: rd_mux = 16'h0000;
    endcase
  end

  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      resp_r <= 1'b0;
      readdata_r <= 32'h00000000;
    end else if (i_clk_en) begin
      resp_r <= req & ~resp_r;
      if (i_avs_read && !resp_r) begin
        readdata_r <= {16'h0000, rd_mux};
      end
    end
  end

  assign o_avs_readdata = readdata_r;
  assign o_cal_start = cal_start_r;
  assign o_ramp_accum = accum_r;
  assign o_ramp_active = running;

  chk_accum_step: assert property (@(posedge i_core_clk) disable iff (i_srst)
    (i_clk_en && tick && state_r == ramp_seq_pkg::ST_FIRST && !adv)
    |=> (accum_r == $past(accum_r) + $past(step_ext)))
    else $error("first segment step not applied");
  chk_double_rate: assert property (@(posedge i_core_clk) disable iff (i_srst)
    (i_clk_en && running && cur_cfg.doubled && half_r && !adv) |=> !tick)
    else $error("doubled segment advanced twice");
  chk_disable_idle: assert property (@(posedge i_core_clk) disable iff (i_srst)
    (i_clk_en && !ramp_en) |=> (state_r == ramp_seq_pkg::ST_IDLE))
    else $error("ramp ran while disabled");
  chk_reserved_hold: assert property (@(posedge i_core_clk) disable iff (i_srst)
    (i_clk_en && ramp_en && running && cur_cfg.advance_source == 2'h3 && !do_cal)
    |=> $stable(state_r))
    else $error("reserved source moved segment");
  chk_second_after: assert property (@(posedge i_core_clk) disable iff (i_srst)
    (i_clk_en && ramp_en && state_r == ramp_seq_pkg::ST_FIRST && adv && !do_cal
     && first_cfg.successor) |=> (state_r == ramp_seq_pkg::ST_SECOND))
    else $error("first segment successor ignored");
  chk_wait_min: assert property (@(posedge i_core_clk) disable iff (i_srst)
    (state_r == ramp_seq_pkg::ST_CAL_WAIT && i_clk_en && ramp_en
     && wait_cnt_r < wait_target) |=> (state_r == ramp_seq_pkg::ST_CAL_WAIT))
    else $error("calibration wait cut short");
  chk_cal_start: assert property (@(posedge i_core_clk) disable iff (i_srst)
    (i_clk_en && ramp_en && do_cal) |=> o_cal_start)
    else $error("calibration not started after sweep");
  chk_band_reset: assert property (@(posedge i_core_clk)
    i_srst |=> (cal_r.band == ramp_seq_pkg::RST_BAND && cal_r.amplitude
                == ramp_seq_pkg::RST_AMPLITUDE))
    else $error("readback reset value wrong");
endmodule // ramp_sequencer
`default_nettype wire

// [sweep_pin_source.sv]
// Purpose: far-side model driving the two sweep trigger pins
// Assumes: pins change just after a rising edge of i_core_clk and idle low
// Notes: WIDTH sets how long a pulse stands, so slow sources can be modelled
`timescale 1ns/1ns
`default_nettype none
module sweep_pin_source #(
  parameter int WIDTH = 1
) (
  input wire logic i_core_clk,
  output logic o_sweep_clock_pin,
  output logic o_sweep_direction_pin
);
  // idle low, as an unused pin tied to ground would be
  initial begin
    o_sweep_clock_pin = 1'b0;
    o_sweep_direction_pin = 1'b0;
  end
  // one rising then one falling edge on the chosen pin
  task automatic pulse(input bit dir);
    @(posedge i_core_clk);
    if (dir) o_sweep_direction_pin <= 1'b1;
    else o_sweep_clock_pin <= 1'b1;
    repeat (WIDTH) @(posedge i_core_clk);
    o_sweep_direction_pin <= 1'b0;
    o_sweep_clock_pin <= 1'b0;
  endtask
endmodule // sweep_pin_source
`default_nettype wire

// [two_segment_frequency_ramp_sequencer_tb.sv]
// Purpose: self-checking bench for the two-segment ramp sequencer
// Assumes: one wait cycle per bus access; manual mode avoids calibration stalls
// Notes: segment lengths are judged by accumulator totals, not by state reads
`timescale 1ns/1ns
`default_nettype none
module two_segment_frequency_ramp_sequencer_tb;
  logic clk, srst, rd, wr_en, cal_done, wait_rq, cal_start, active, cpin, dpin, clk_en;
  logic [8:0] addr;
  logic [3:0] be;
  logic [31:0] wdata, rdata, accum;
  ramp_seq_pkg::cal_result_type cal_res;
  int bad_count, compares;
  ramp_sequencer i_dut (
    .i_core_clk(clk), .i_srst(srst), .i_clk_en(clk_en), .i_avs_address(addr),
    .i_avs_read(rd), .i_avs_write(wr_en), .i_avs_writedata(wdata),
    .i_avs_byteenable(be), .o_avs_readdata(rdata), .o_avs_waitrequest(wait_rq),
    .i_sweep_clock_pin(cpin), .i_sweep_direction_pin(dpin), .i_cal_done(cal_done),
    .i_cal_result(cal_res), .o_cal_start(cal_start), .o_ramp_accum(accum),
    .o_ramp_active(active));
  sweep_pin_source i_src (.i_core_clk(clk), .o_sweep_clock_pin(cpin),
    .o_sweep_direction_pin(dpin));
  task automatic results();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic access(input logic [6:0] idx, input bit w, input logic [15:0] d,
                        output logic [31:0] q);
    int n;
    @(posedge clk);
    addr <= {idx, 2'b00};
    wdata <= {16'h0000, d};
    rd <= !w;
    wr_en <= w;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (wait_rq !== 1'b0 && n < 20);
    q = rdata;
    rd <= 1'b0;
    wr_en <= 1'b0;
    if (n >= 20) begin
      check("bus answer", 32'h0, 32'h1);
      results();
    end
  endtask
  task automatic wr(input logic [6:0] idx, input logic [15:0] d);
    logic [31:0] q;
    access(idx, 1'b1, d, q);
  endtask
  task automatic rd_chk(input string what, input logic [6:0] idx, input logic [15:0] e);
    logic [31:0] q;
    access(idx, 1'b0, 16'h0000, q);
    check(what, q, {16'h0000, e});
  endtask
  task automatic setup(input logic [29:0] s1, input logic d1, input logic [15:0] seq,
                       input logic [29:0] s2, input logic [15:0] l1, l2, mode);
    logic [31:0] a;
    wr(ramp_seq_pkg::IDX_GLOBAL_CTRL, 16'h0000);
    repeat (2) @(posedge clk);
    a = accum;
    repeat (3) @(posedge clk);
    check("idle when disabled", {31'h0, active}, 32'h0);
    check("accumulator frozen", accum, a);
    wr(ramp_seq_pkg::IDX_FIRST_STEP_HIGH, {s1[29:16], 1'b0, d1});
    wr(ramp_seq_pkg::IDX_FIRST_STEP_LOW, s1[15:0]);
    wr(ramp_seq_pkg::IDX_FIRST_LENGTH, l1);
    wr(ramp_seq_pkg::IDX_SEGMENT_SEQUENCE_CONTROL, seq);
    wr(ramp_seq_pkg::IDX_SECOND_STEP_HIGH, {2'b00, s2[29:16]});
    wr(ramp_seq_pkg::IDX_SECOND_STEP_LOW, s2[15:0]);
    wr(ramp_seq_pkg::IDX_SECOND_LENGTH, l2);
    wr(ramp_seq_pkg::IDX_CALIBRATION_WAIT_AND_MODE, mode);
  endtask
  task automatic wait_start();
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (cal_start !== 1'b1 && n < 60);
    check("calibration start", 32'(n < 60), 32'h1);
    if (n >= 60) results();
  endtask
  task automatic t_reset();
    rd_chk("band reset", ramp_seq_pkg::IDX_BAND_CODE_READBACK, 16'h00B7);
    rd_chk("amplitude reset", ramp_seq_pkg::IDX_AMPLITUDE_READBACK, 16'h00AA);
    rd_chk("lock reset", ramp_seq_pkg::IDX_LOCK_AND_CORE_READBACK, 16'h0000);
    rd_chk("scale reset", ramp_seq_pkg::IDX_CALIBRATION_SCALE_CONTROL, 16'h0007);
    wr(ramp_seq_pkg::IDX_BAND_CODE_READBACK, 16'h0000);
    rd_chk("band read only", ramp_seq_pkg::IDX_BAND_CODE_READBACK, 16'h00B7);
    wr(ramp_seq_pkg::IDX_FIRST_LENGTH, 16'hA5C3);
    be <= 4'hC;
    wr(ramp_seq_pkg::IDX_FIRST_LENGTH, 16'h0000);
    be <= 4'hF;
    rd_chk("length kept", ramp_seq_pkg::IDX_FIRST_LENGTH, 16'hA5C3);
    rd_chk("unmapped", 7'h10, 16'h0000);
    $display("test reset done");
  endtask
  // second segment has zero step and a reserved source, so it must park
  task automatic t_length(input bit dbl, input bit neg);
    logic [31:0] a0, prev;
    int first, last;
    setup(neg ? 30'h3FFFFFFF : 30'h1, dbl, 16'h0010, 30'h0, 16'h0005, 16'h0000, 16'h0023);
    a0 = accum;
    prev = a0;
    first = -1;
    last = -1;
    wr(ramp_seq_pkg::IDX_GLOBAL_CTRL, 16'h8000);
    for (int i = 0; i < 60; i++) begin
      @(posedge clk);
      if (accum !== prev) begin
        if (first < 0) first = i;
        last = i;
      end
      prev = accum;
    end
    check("first total", accum - a0, neg ? 32'hFFFFFFFB : 32'h5);
    check("first span", 32'(last - first), dbl ? 32'h8 : 32'h4);
    $display("test length done");
  endtask
  task automatic t_trigger(input int i);
    logic [3:0] codes [6] = '{ramp_seq_pkg::TRG_CLK_RISE, ramp_seq_pkg::TRG_DIR_RISE,
      ramp_seq_pkg::TRG_CLK_FALL, ramp_seq_pkg::TRG_DIR_FALL, ramp_seq_pkg::TRG_CLK_RISE,
      ramp_seq_pkg::TRG_ALWAYS};
    logic [3:0] c;
    logic [31:0] a0;
    c = codes[i];
    setup(30'h0, 1'b0, i == 4 ? 16'h0012 : 16'h0011, 30'h1, 16'h0000, 16'h0003, 16'h0020);
    wr(ramp_seq_pkg::IDX_TRIGGER_SEL, i == 4 ? {5'h00, c, 7'h00} : {9'h000, c, 3'h0});
    wr(ramp_seq_pkg::IDX_GLOBAL_CTRL, 16'h8000);
    repeat (10) @(posedge clk);
    a0 = accum;
    if (c == ramp_seq_pkg::TRG_ALWAYS) begin
      repeat (25) @(posedge clk);
      check("always fires", 32'((accum - a0) >= 32'h3), 32'h1);
      // a low clock enable must freeze the running accumulator
      clk_en <= 1'b0;
      @(posedge clk);
      a0 = accum;
      repeat (8) @(posedge clk);
      check("frozen by enable", accum, a0);
      clk_en <= 1'b1;
    end else begin
      i_src.pulse(!c[1]);
      repeat (10) @(posedge clk);
      check("no advance", accum - a0, 32'h0);
      i_src.pulse(c[1]);
      repeat (15) @(posedge clk);
      check("advance", accum - a0, 32'h3);
    end
    $display("test trigger done");
  endtask
  task automatic t_auto_cal();
    int n;
    cal_res <= '{lock_status: 2'h2, core: 3'h5, band: 8'h3C, amplitude: 9'h155};
    setup(30'h1, 1'b0, 16'h0000, 30'h0, 16'h0002, 16'h0000, 16'h00C0);
    wr(ramp_seq_pkg::IDX_CALIBRATION_SCALE_CONTROL, 16'h0011);
    wr(ramp_seq_pkg::IDX_GLOBAL_CTRL, 16'h8000);
    wait_start();
    n = 0;
    repeat (30) begin
      @(posedge clk);
      if (active !== 1'b0) n++;
    end
    check("held for calibration", 32'(n), 32'h0);
    cal_done <= 1'b1;
    wait_start();
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (active !== 1'b1 && n < 20);
    check("wait floor", 32'(n >= 6 && n <= 9), 32'h1);
    if (n >= 20) results();
    rd_chk("lock and core", ramp_seq_pkg::IDX_LOCK_AND_CORE_READBACK, 16'h04A0);
    rd_chk("band", ramp_seq_pkg::IDX_BAND_CODE_READBACK, 16'h003C);
    rd_chk("amplitude", ramp_seq_pkg::IDX_AMPLITUDE_READBACK, 16'h0155);
    wr(ramp_seq_pkg::IDX_CALIBRATION_WAIT_AND_MODE, 16'h00E0);
    repeat (5) @(posedge clk);
    n = 0;
    repeat (40) begin
      @(posedge clk);
      if (cal_start !== 1'b0) n++;
    end
    check("manual no calibration", 32'(n), 32'h0);
    $display("test calibration done");
  endtask
  // residue clear is only set in automatic mode; second segment parks on a reserved source
  task automatic t_residue(input bit clr);
    logic [31:0] a0;
    setup(30'h1, 1'b0, clr ? 16'h0030 : 16'h0010, 30'h0, 16'h0004, 16'h0000, 16'h0003);
    a0 = accum;
    wr(ramp_seq_pkg::IDX_GLOBAL_CTRL, 16'h8000);
    repeat (20) @(posedge clk);
    check("residue", clr ? accum : accum - a0, clr ? 32'h0 : 32'h4);
    $display("test residue done");
  endtask
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    srst = 1'b1;
    rd = 1'b0;
    wr_en = 1'b0;
    addr = 9'h000;
    wdata = 32'h0;
    be = 4'hF;
    clk_en = 1'b1;
    cal_done = 1'b0;
    cal_res = '0;
    bad_count = 0;
    compares = 0;
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    t_reset();
    t_length(1'b0, 1'b0);
    t_length(1'b1, 1'b1);
    for (int i = 0; i < 6; i++) t_trigger(i);
    t_auto_cal();
    t_residue(1'b1);
    t_residue(1'b0);
    results();
  end
endmodule // two_segment_frequency_ramp_sequencer_tb
`default_nettype wire
